// file: dv/scps_osc_model.sv
// Partner model: system and watch oscillator clock enables
`timescale 1ns/1ps
`default_nettype none
module scps_osc_model (
    // Clock and pace
    input  wire logic i_ref_clk,
    input  wire logic i_slow,
    // Enables
    output logic      o_sys_clk_en,
    output logic      o_watch_clk_en
);
    logic [1:0] ph_reg = 2'h0;
    always_ff @(posedge i_ref_clk) ph_reg <= ph_reg + 2'h1;
    // Slow pace keeps the watch clock well below the system clock
    assign o_sys_clk_en   = !i_slow || ph_reg[0];
    assign o_watch_clk_en = !i_slow || (ph_reg == 2'h3);
endmodule // scps_osc_model
`default_nettype wire

// file: dv/scps_props.sv
// Checker: source latch and prescaler assertions on the top ports
`timescale 1ns/1ps
`default_nettype none
module scps_props
    import scps_pkg::*;
#(
    parameter int unsigned SYS_W   = SYS_PRESC_W,
    parameter int unsigned WATCH_W = WATCH_PRESC_W
) (
    // Clock, resets and controls
    input wire logic               i_ref_clk,
    input wire logic               i_rst_n,
    input wire logic               i_ext_rst_n,
    input wire logic               i_por_rst_n,
    input wire logic               i_wdt_rst_n,
    input wire logic               i_osc_select_pin,
    input wire logic               i_sys_clk_en,
    input wire logic               i_watch_clk_en,
    input wire scps_mode_t         i_mode,
    input wire logic               i_medium_divider_bit_high,
    input wire logic               i_medium_divider_bit_low,
    // Watched outputs
    input wire logic               o_oscillator_source_flag,
    input wire logic               o_select_pin_level_flag,
    input wire logic [SYS_W-1:0]   o_sys_presc_tap,
    input wire logic [WATCH_W-1:0] o_watch_presc_tap
);
    // ==========
    // Qualifiers
    wire logic src = i_ext_rst_n & i_por_rst_n;
    wire logic nr  = src & i_wdt_rst_n;
    wire logic low = i_mode inside {SCPS_MODE_STANDBY, SCPS_MODE_WATCH,
        SCPS_MODE_SUBACTIVE, SCPS_MODE_SUBSLEEP};
    wire logic hi  = nr & i_sys_clk_en & (i_mode == SCPS_MODE_ACTIVE_HI);
    wire logic m8  = nr & i_sys_clk_en & !i_medium_divider_bit_high & !i_medium_divider_bit_low
        & (i_mode inside {SCPS_MODE_ACTIVE_MED, SCPS_MODE_SLEEP_MED});
    wire logic wr  = nr & i_watch_clk_en & (i_mode != SCPS_MODE_STANDBY);
    wire logic sb  = nr & (i_mode == SCPS_MODE_STANDBY);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // ==========
    // Assertions
    src_hold_a: assert property (src[*5] |->
        $stable({o_oscillator_source_flag, o_select_pin_level_flag})) else $error("flag moved");
    src_take_a: assert property (!src ##1 src[*5] |->
        {o_oscillator_source_flag, o_select_pin_level_flag} == {2{$past(i_osc_select_pin, 5)}})
        else $error("flag not pin level");
    sys_step_a: assert property (hi[*4] |->
        o_sys_presc_tap == $past(o_sys_presc_tap) + 1'b1) else $error("system step");
    sys_stop_a: assert property (low[*3] |-> o_sys_presc_tap == '0)
        else $error("system count not cleared");
    med_div_a: assert property (m8[*8] |-> ##2
        o_sys_presc_tap == $past(o_sys_presc_tap, 8) + 1'b1) else $error("medium step");
    rst_clear_a: assert property (!nr |-> ##2
        (o_sys_presc_tap == '0 && o_watch_presc_tap == '0)) else $error("taps not cleared");
    watch_freeze_a: assert property (sb[*3] |-> $stable(o_watch_presc_tap))
        else $error("watch count moved");
    watch_step_a: assert property (wr[*7] |->
        o_watch_presc_tap == $past(o_watch_presc_tap, 4) + 1'b1) else $error("watch step");
    cover property (sb[*3]);
    cover property (m8[*8]);
    cover property (!src ##1 src[*5] ##0 o_oscillator_source_flag);
endmodule // scps_props
bind scps_top scps_props #(.SYS_W(SYS_W), .WATCH_W(WATCH_W)) scps_props_i (.*);
`default_nettype wire

// file: dv/scps_top_tb.sv
// Testbench: clock source latch and prescaler scenarios
`timescale 1ns/1ps
`default_nettype none
module scps_top_tb;
    import scps_pkg::*;
    // ==========
    // Signals
    logic                     clk = 1'b0;
    logic                     rst_n = 1'b0, ext_n = 1'b0, por_n = 1'b0, wdt_n = 1'b1;
    logic                     pin = 1'b0, slow = 1'b0, dh = 1'b0, dl = 1'b0;
    scps_mode_t               mode = SCPS_MODE_ACTIVE_HI;
    logic                     s_en, w_en, src_f, lvl_f;
    logic [SYS_PRESC_W-1:0]   st;
    logic [WATCH_PRESC_W-1:0] wt;
    int                       error_cnt = 0;
    int                       check_count = 0;
    scps_top scps_top_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_ext_rst_n(ext_n),
        .i_por_rst_n(por_n), .i_wdt_rst_n(wdt_n), .i_osc_select_pin(pin),
        .i_sys_clk_en(s_en), .i_watch_clk_en(w_en), .i_mode(mode),
        .i_medium_divider_bit_high(dh), .i_medium_divider_bit_low(dl),
        .o_oscillator_source_flag(src_f), .o_select_pin_level_flag(lvl_f),
        .o_sys_presc_tap(st), .o_watch_presc_tap(wt));
    scps_osc_model scps_osc_model_i (.i_ref_clk(clk), .i_slow(slow), .o_sys_clk_en(s_en),
        .o_watch_clk_en(w_en));
    // ==========
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [16:0] seen, input logic [16:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ==========
    // Scenarios
    task automatic t_select();
        pin = 1'b1;
        ext_n = 1'b0;
        tick(3);
        chk("sys tap in reset", st, '0);
        chk("watch tap in reset", wt, '0);
        ext_n = 1'b1;
        tick(6);
        chk("source flag", src_f, 1'b1);
        chk("level flag", lvl_f, 1'b1);
        pin = 1'b0;
        wdt_n = 1'b0;
        tick(2);
        wdt_n = 1'b1;
        tick(6);
        chk("flag after watchdog", src_f, 1'b1);
        por_n = 1'b0;
        tick(3);
        por_n = 1'b1;
        tick(6);
        chk("flag after power-on", src_f, 1'b0);
        chk("level flag low", lvl_f, 1'b0);
    endtask
    task automatic t_sys();
        logic [16:0] v;
        logic [7:0]  w;
        v = st;
        w = wt;
        tick(20);
        chk("sys count fast", st - v, 17'h14);
        chk("watch count fast", 8'(wt - w), 8'h5);
        slow = 1'b1;
        tick(3);
        v = st;
        w = wt;
        tick(48);
        chk("sys count slow", st - v, 17'h18);
        chk("watch count slow", 8'(wt - w), 8'h3);
        slow = 1'b0;
        mode = SCPS_MODE_SLEEP_HI;
        tick(3);
        v = st;
        w = wt;
        tick(16);
        chk("sys count sleep", st - v, 17'h10);
        chk("watch count sleep", 8'(wt - w), 8'h4);
    endtask
    task automatic t_medium();
        logic [16:0] v;
        for (int s = 0; s < 4; s++) begin
            {dh, dl} = 2'(s);
            mode = s[0] ? SCPS_MODE_SLEEP_MED : SCPS_MODE_ACTIVE_MED;
            tick(3);
            v = st;
            tick(32 << s);
            chk("medium count", st - v, 17'h4);
        end
    endtask
    task automatic t_lowpw();
        scps_mode_t m [4] = '{SCPS_MODE_STANDBY, SCPS_MODE_WATCH, SCPS_MODE_SUBACTIVE,
            SCPS_MODE_SUBSLEEP};
        logic [7:0] w;
        for (int i = 0; i < 4; i++) begin
            mode = SCPS_MODE_ACTIVE_HI;
            tick(5);
            mode = m[i];
            tick(3);
            w = wt;
            tick(8);
            chk("sys tap stopped", st, '0);
            chk("watch count low power", 8'(wt - w), (i == 0) ? 8'h0 : 8'h2);
        end
    endtask
    // ==========
    // Main sequence
    initial forever #5 clk = ~clk;
    initial begin
        tick(12);
        rst_n = 1'b1;
        ext_n = 1'b1;
        por_n = 1'b1;
        tick(4);
        chk("flag after reset", src_f, 1'b0);
        t_select();
        t_sys();
        t_medium();
        t_lowpw();
        test_done();
    end
endmodule // scps_top_tb
`default_nettype wire

// file: logic/scps_clk_divider.sv
// Module: programmable enable divider producing one-cycle ticks
`timescale 1ns/1ps
`default_nettype none
module scps_clk_divider #(
    parameter int unsigned CNT_W = 6
) (
    // Clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst_n,
    // Control
    input  wire logic             i_clear,
    input  wire logic             i_in_tick,
    input  wire logic [CNT_W-1:0] i_last,
    // Output
    output logic                  o_tick
);

    // ==================================================
    // Counter
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    wire              at_last = (cnt_reg >= i_last);

    assign cnt_next = at_last ? '0 : cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    assign o_tick   = i_in_tick && at_last && !i_clear;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || i_clear) begin
            cnt_reg <= '0;
        end else if (i_in_tick) begin
            cnt_reg <= cnt_next;
        end
    end

endmodule // scps_clk_divider
`default_nettype wire

// file: logic/scps_counter.sv
// Module: free-running prescaler up-counter with clear and stop
`timescale 1ns/1ps
`default_nettype none
module scps_counter #(
    parameter int unsigned W = 8
) (
    // Clock and reset
    input  wire logic         i_ref_clk,
    input  wire logic         i_rst_n,
    // Control
    input  wire logic         i_clear,
    input  wire logic         i_count_en,
    // Count
    output logic [W-1:0]      o_count
);

    // ==================================================
    // Counter
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;

    assign cnt_next = cnt_reg + {{(W-1){1'b0}}, 1'b1};
    assign o_count  = cnt_reg;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || i_clear) begin
            cnt_reg <= '0;
        end else if (i_count_en) begin
            cnt_reg <= cnt_next;
        end
    end

endmodule // scps_counter
`default_nettype wire

// file: logic/scps_pkg.sv
// Package: constants and types for clock source select and prescalers
package scps_pkg;

    // ==================================================
    // Counter widths and reset values
    localparam int unsigned SYS_PRESC_W   = 17;
    localparam int unsigned WATCH_PRESC_W = 8;
    localparam logic [SYS_PRESC_W-1:0]   SYS_PRESC_RST   = 17'h00000;
    localparam logic [WATCH_PRESC_W-1:0] WATCH_PRESC_RST = 8'h00;

    // ==================================================
    // Watch clock pre-divide (watch clock / 4)
    localparam int unsigned WATCH_PREDIV   = 4;
    localparam int unsigned WATCH_PREDIV_W = 2;

    // ==================================================
    // Medium-speed divider field encodings and ratios
    localparam logic [1:0] MED_DIV_8  = 2'h0;
    localparam logic [1:0] MED_DIV_16 = 2'h1;
    localparam logic [1:0] MED_DIV_32 = 2'h2;
    localparam logic [1:0] MED_DIV_64 = 2'h3;
    localparam int unsigned MED_DIV_CNT_W = 6;

    // ==================================================
    // Flag encodings
    localparam logic SRC_SYSTEM_OSC  = 1'b0;
    localparam logic SRC_ONCHIP_OSC  = 1'b1;
    localparam logic SRC_RESET_VALUE = SRC_SYSTEM_OSC;

    // ==================================================
    // Power modes
    typedef enum logic [2:0] {
        SCPS_MODE_ACTIVE_HI,
        SCPS_MODE_ACTIVE_MED,
        SCPS_MODE_SLEEP_HI,
        SCPS_MODE_SLEEP_MED,
        SCPS_MODE_SUBACTIVE,
        SCPS_MODE_SUBSLEEP,
        SCPS_MODE_WATCH,
        SCPS_MODE_STANDBY
    } scps_mode_t;

    // Medium-speed divider terminal count (ratio minus one)
    function automatic logic [MED_DIV_CNT_W-1:0] med_div_last(input logic [1:0] sel);
        case (sel)
            MED_DIV_8:  med_div_last = 6'h07;
            MED_DIV_16: med_div_last = 6'h0f;
            MED_DIV_32: med_div_last = 6'h1f;
            default:    med_div_last = 6'h3f;
        endcase
    endfunction

endpackage

// file: logic/scps_top.sv
// Module: system clock source latch and the two prescalers
//
// Summary of operation
// - Select pin low system osc, high on-chip
// - Capture select pin at reset release, hold
// - Only external or power-on reset resamples
// - Both flags 0 system osc, 1 on-chip
// - System prescaler is 17-bit system-clock up-counter
// - System prescaler cleared by reset, then counts
// - Low-power modes stop and clear system prescaler
// - No processor access to system prescaler
// - Medium-speed modes divide system prescaler input
// - Medium divider ratios 8, 16, 32, 64
// - Watch prescaler 8-bit on watch clock/4
// - Watch prescaler cleared by reset, then counts
// - Watch prescaler stops only in standby
`timescale 1ns/1ps
`default_nettype none
module scps_top
    import scps_pkg::*;
#(
    parameter int unsigned SYS_W   = SYS_PRESC_W,
    parameter int unsigned WATCH_W = WATCH_PRESC_W
) (
    // Clock and resets
    input  wire logic               i_ref_clk,
    input  wire logic               i_rst_n,
    input  wire logic               i_ext_rst_n,
    input  wire logic               i_por_rst_n,
    input  wire logic               i_wdt_rst_n,
    // Clock source select
    input  wire logic               i_osc_select_pin,
    // System clock and watch clock enables
    input  wire logic               i_sys_clk_en,
    input  wire logic               i_watch_clk_en,
    // Power mode and medium divider field
    input  wire scps_mode_t         i_mode,
    input  wire logic               i_medium_divider_bit_high,
    input  wire logic               i_medium_divider_bit_low,
    // Clock source flags
    output logic                    o_oscillator_source_flag,
    output logic                    o_select_pin_level_flag,
    // Prescaler taps
    output logic [SYS_W-1:0]        o_sys_presc_tap,
    output logic [WATCH_W-1:0]      o_watch_presc_tap
);

    // ==================================================
    // Reset qualification
    // The core reset covers all sources; only external and power-on
    // resets are allowed to resample the select pin.
    wire core_rst_n  = i_rst_n && i_ext_rst_n && i_por_rst_n && i_wdt_rst_n;
    wire sample_rst  = !i_ext_rst_n || !i_por_rst_n;

    logic sample_rst_reg;
    logic osc_src_reg;
    logic osc_src_next;
    wire  sample_win = sample_rst || sample_rst_reg;

    // Pin is tracked while the qualifying reset is asserted, taken once
    // more on the release edge and frozen after it, so a watchdog reset
    // leaves the choice intact.
    assign osc_src_next = sample_win ? i_osc_select_pin : osc_src_reg;

    // Kept running under the global reset so that releasing all resets
    // together still takes the pin level.
    always_ff @(posedge i_ref_clk) begin
        sample_rst_reg <= sample_rst;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            osc_src_reg <= SRC_RESET_VALUE;
        end else if (sample_win) begin
            osc_src_reg <= osc_src_next;
        end
    end

    // ==================================================
    // Flags: both report the latched choice
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_oscillator_source_flag <= SRC_RESET_VALUE;
            o_select_pin_level_flag  <= SRC_RESET_VALUE;
        end else begin
            o_oscillator_source_flag <= osc_src_reg;
            o_select_pin_level_flag  <= osc_src_reg;
        end
    end

    // ==================================================
    // Mode decode
    wire sys_stop = (i_mode == SCPS_MODE_STANDBY)  || (i_mode == SCPS_MODE_WATCH) ||
                    (i_mode == SCPS_MODE_SUBACTIVE) || (i_mode == SCPS_MODE_SUBSLEEP);
    wire med_mode = (i_mode == SCPS_MODE_ACTIVE_MED) || (i_mode == SCPS_MODE_SLEEP_MED);
    wire watch_stop = (i_mode == SCPS_MODE_STANDBY);

    wire [1:0] med_sel = {i_medium_divider_bit_high, i_medium_divider_bit_low};
    wire [MED_DIV_CNT_W-1:0] med_last = med_div_last(med_sel);

    // ==================================================
    // Medium-speed input divider for the system prescaler
    // Held cleared outside medium-speed modes so a later entry starts
    // on a full divided period.
    wire med_tick;

    scps_clk_divider #(
        .CNT_W     (MED_DIV_CNT_W)
    ) u_med_div (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (core_rst_n),
        .i_clear   (!med_mode || sys_stop),
        .i_in_tick (i_sys_clk_en),
        .i_last    (med_last),
        .o_tick    (med_tick)
    );

    wire sys_count_en = med_mode ? med_tick : i_sys_clk_en;

    // ==================================================
    // System prescaler: no processor path exists to this count
    wire [SYS_W-1:0] sys_count;

    scps_counter #(
        .W          (SYS_W)
    ) u_sys_presc (
        .i_ref_clk  (i_ref_clk),
        .i_rst_n    (core_rst_n),
        .i_clear    (sys_stop),
        .i_count_en (sys_count_en),
        .o_count    (sys_count)
    );

    // ==================================================
    // Watch clock divided by four
    localparam logic [WATCH_PREDIV_W-1:0] WATCH_LAST = WATCH_PREDIV_W'(WATCH_PREDIV - 1);
    wire watch_tick;

    scps_clk_divider #(
        .CNT_W     (WATCH_PREDIV_W)
    ) u_watch_div (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (core_rst_n),
        .i_clear   (1'b0),
        .i_in_tick (i_watch_clk_en && !watch_stop),
        .i_last    (WATCH_LAST),
        .o_tick    (watch_tick)
    );

    // ==================================================
    // Watch prescaler: stops but keeps its count in standby
    wire [WATCH_W-1:0] watch_count;

    scps_counter #(
        .W          (WATCH_W)
    ) u_watch_presc (
        .i_ref_clk  (i_ref_clk),
        .i_rst_n    (core_rst_n),
        .i_clear    (1'b0),
        .i_count_en (watch_tick),
        .o_count    (watch_count)
    );

    // ==================================================
    // Taps: bit n toggles at input rate / 2^(n+1); registered outputs
    always_ff @(posedge i_ref_clk) begin
        if (!core_rst_n) begin
            o_sys_presc_tap   <= SYS_PRESC_RST;
            o_watch_presc_tap <= WATCH_PRESC_RST;
        end else begin
            o_sys_presc_tap   <= sys_count;
            o_watch_presc_tap <= watch_count;
        end
    end

endmodule // scps_top
`default_nettype wire
